// file: verilog/mmlpc_regs.vh
// Register addresses, field positions, reset values and encodings of the lockdown checker
`ifndef MMLPC_REGS_VH
`define MMLPC_REGS_VH

`define MMLPC_SECCFG_ADDR      12'h747
`define MMLPC_SECCFG_HI_ADDR   12'h757
`define MMLPC_SECCFG_RESET     64'h0000000000000000
`define MMLPC_SECCFG_MML_BIT   0
`define MMLPC_SECCFG_MACHINE_ALLOWLIST_POLICY_BIT  1
`define MMLPC_SECCFG_RLB_BIT   2

`define MMLPC_CFG_R_BIT        0
`define MMLPC_CFG_W_BIT        1
`define MMLPC_CFG_X_BIT        2
`define MMLPC_CFG_A_LSB        3
`define MMLPC_CFG_A_MSB        4
`define MMLPC_CFG_L_BIT        7
`define MMLPC_CFG_RESET        8'h00
`define MMLPC_ADDR_RESET       1'b0

`define MMLPC_A_OFF            2'h0
`define MMLPC_A_TOR            2'h1
`define MMLPC_A_NA4            2'h2
`define MMLPC_A_NAPOT          2'h3

`define MMLPC_PRIV_M           2'h3

`define MMLPC_ACC_READ         2'h0
`define MMLPC_ACC_WRITE        2'h1
`define MMLPC_ACC_EXEC         2'h2

`endif

// file: verilog/mmlpc_entry_perm.v
// Permission decode of the deciding entry for one access
`timescale 1ns/10ps
`include "mmlpc_regs.vh"

module mmlpc_entry_perm (
  input  wire       matched,
  input  wire [3:0] lrwx,
  input  wire       machineLockdown,
  input  wire       machineAllowlistPolicy,
  input  wire       isMachine,
  input  wire [1:0] accType,
  output reg        allow
);

  reg l;
  reg r;
  reg w;
  reg x;
  reg pr;
  reg pw;
  reg px;
  reg shared;

  always @* begin
    l      = lrwx[3];
    r      = lrwx[2];
    w      = lrwx[1];
    x      = lrwx[0];
    pr     = 1'b0;
    pw     = 1'b0;
    px     = 1'b0;
    shared = machineLockdown & ((~r & w) | (l & r & w & x)); // RL13 RL20
    if (!matched) begin
      if (isMachine) begin
        pr = ~machineAllowlistPolicy; // RL8
        pw = ~machineAllowlistPolicy; // RL8
        px = ~machineAllowlistPolicy & ~machineLockdown; // RL19
      end
    end else if (!machineLockdown) begin
      if (!l && isMachine) begin
        pr = 1'b1; // RL10
        pw = 1'b1;
        px = 1'b1;
      end else begin
        // Write without read stays reserved, so the write grant needs read as well
        pr = r; // RL10 RL20
        pw = r & w;
        px = x;
      end
    end else if (shared) begin
      if (l & r & w & x) begin
        pr = 1'b1; // RL16
      end else if (!l) begin
        pr = 1'b1; // RL14
        pw = isMachine | x;
      end else begin
        px = 1'b1; // RL15
        pr = isMachine & x;
      end
    end else if (l) begin
      if (isMachine) begin
        pr = r; // RL11
        pw = w;
        px = x; // RL19
      end
    end else if (!isMachine) begin
      pr = r; // RL12
      pw = w;
      px = x;
    end
    case (accType)
      `MMLPC_ACC_READ:  allow = pr;
      `MMLPC_ACC_WRITE: allow = pw;
      `MMLPC_ACC_EXEC:  allow = px;
      default:          allow = 1'b0;
    endcase
  end

endmodule

// file: verilog/mmlpc_checker.v
// Machine-mode lockdown protection checker with its security configuration register
`timescale 1ns/10ps
`include "mmlpc_regs.vh"

// Operation
// RL1 - 64-bit config register, machine mode only
// RL2 - Defined fields legalised, undefined bits read zero
// RL3 - Config register clears to zero on reset
// RL4 - Bypass set lets locked entries be written
// RL5 - Bypass stuck zero once any entry locked
// RL6 - Bypass may be tied to zero
// RL7 - Allowlist policy sticky until reset
// RL8 - Allowlist denies unmatched machine accesses
// RL9 - Lockdown sticky until reset
// RL10 - Without lockdown, unlocked rules ignored by machine
// RL11 - Lockdown: locked entries machine only
// RL12 - Lockdown: unlocked entries user/supervisor only
// RL13 - Lockdown: shared encodings enforced everywhere
// RL14 - Unlocked shared region never executable
// RL15 - Locked shared region never writable
// RL16 - All-ones pattern is read-only, locked
// RL17 - Locked entries ignore writes unless bypass
// RL18 - Lockdown drops executable locked config writes
// RL19 - Lockdown limits machine fetch to machine rules
// RL20 - Without lockdown write-only encoding stays reserved
// RL21 - Denied accesses raise access fault
// RL22 - Active rule needs mode on, ordered range
// RL23 - Lowest-numbered matching entry decides
module mmlpc_checker #(
  parameter XLEN       = 32,
  parameter N          = 8,
  parameter IDX_W      = 3,
  parameter PA_W       = 34,
  parameter RLB_EN     = 1
) (
  input  wire                sys_clk,
  input  wire                reset_n,
  input  wire                csrValid,
  input  wire                csrWrite,
  input  wire [11:0]         csrAddr,
  input  wire [XLEN-1:0]     csrWrData,
  input  wire [1:0]          csrPriv,
  output reg                 csrAck,
  output reg                 csrIllegal,
  output reg  [XLEN-1:0]     csrRdData,
  input  wire                cfgWrEn,
  input  wire [IDX_W-1:0]    cfgWrIdx,
  input  wire [7:0]          cfgWrData,
  input  wire                addrWrEn,
  input  wire [IDX_W-1:0]    addrWrIdx,
  input  wire [PA_W-3:0]     addrWrData,
  input  wire [IDX_W-1:0]    entryRdIdx,
  output reg  [7:0]          entryRdCfg,
  output reg  [PA_W-3:0]     entryRdAddr,
  input  wire                chkValid,
  input  wire [PA_W-1:0]     chkAddr,
  input  wire [1:0]          chkType,
  input  wire [1:0]          chkPriv,
  output reg                 chkDone,
  output reg                 chkFault,
  output reg                 chkMatched,
  output reg  [IDX_W-1:0]    chkEntry,
  output wire                ruleLockBypass,
  output wire                machineAllowlistPolicy,
  output wire                machineLockdown
);

  localparam AW = PA_W - 2;

  reg  [7:0]    cfgMem [0:N-1];
  reg  [AW-1:0] addrMem [0:N-1];
  reg  [2:0]    secCfg;
  reg  [2:0]    next_secCfg;
  reg           anyLocked;
  reg           hit;
  reg  [IDX_W-1:0] hitIdx;
  reg  [3:0]    hitLrwx;
  reg           csrMapped;
  reg           csrIsM;
  reg  [63:0]   secCfgWide;
  reg  [XLEN-1:0] next_rdData;
  wire          allow;
  wire [AW-1:0] chkWord;
  wire          chkIsM;
  wire          secCfgWr;
  integer       i;
  integer       j;

  localparam [63:0] SECCFG_RST = `MMLPC_SECCFG_RESET;

  assign chkWord                = chkAddr[PA_W-1:2];
  assign chkIsM                 = (chkPriv == `MMLPC_PRIV_M);
  assign secCfgWr               = csrValid && csrWrite && (csrPriv == `MMLPC_PRIV_M) && (csrAddr == `MMLPC_SECCFG_ADDR);
  assign ruleLockBypass         = secCfg[`MMLPC_SECCFG_RLB_BIT];
  assign machineAllowlistPolicy = secCfg[`MMLPC_SECCFG_MACHINE_ALLOWLIST_POLICY_BIT];
  assign machineLockdown        = secCfg[`MMLPC_SECCFG_MML_BIT];

  // Naturally aligned power-of-two region: trailing ones of the entry address size the mask
  function napotHit;
    input [AW-1:0] a;
    input [AW-1:0] wd;
    reg   [AW-1:0] msk;
    begin
      msk      = a ^ (a + {{(AW-1){1'b0}}, 1'b1});
      napotHit = ((a & ~msk) == (wd & ~msk));
    end
  endfunction

  // Lock blocks writes only while bypass is clear
  function entryLocked;
    input [7:0] cfg;
    input       bypass;
    begin
      entryLocked = cfg[`MMLPC_CFG_L_BIT] & ~bypass; // RL4 RL17
    end
  endfunction

  // Executable machine-only or locked shared encodings may not be added under lockdown
  function execLockedCfg;
    input [7:0] cfg;
    reg         l;
    reg         r;
    reg         w;
    reg         x;
    begin
      l = cfg[`MMLPC_CFG_L_BIT];
      r = cfg[`MMLPC_CFG_R_BIT];
      w = cfg[`MMLPC_CFG_W_BIT];
      x = cfg[`MMLPC_CFG_X_BIT];
      execLockedCfg = l & ~(r & w & x) & (x | (~r & w)); // RL18
    end
  endfunction

  // Address-matching mode field of an entry configuration byte
  function [1:0] matchMode;
    input [7:0] cfg;
    begin
      matchMode = cfg[`MMLPC_CFG_A_MSB:`MMLPC_CFG_A_LSB];
    end
  endfunction

  // Lock, read, write and execute bits in the order the permission decode expects
  function [3:0] lrwxOf;
    input [7:0] cfg;
    begin
      lrwxOf = {cfg[`MMLPC_CFG_L_BIT], cfg[`MMLPC_CFG_R_BIT], cfg[`MMLPC_CFG_W_BIT], cfg[`MMLPC_CFG_X_BIT]};
    end
  endfunction

  // A locked range entry above uses this address as its lower bound, so it pins it too
  function torGuarded;
    input [7:0] upperCfg;
    input       bypass;
    begin
      torGuarded = entryLocked(upperCfg, bypass) && (matchMode(upperCfg) == `MMLPC_A_TOR);
    end
  endfunction

  // Lowest-numbered active matching entry wins, so scan downward and let later hits overwrite
  always @* begin
    hit       = 1'b0;
    hitIdx    = {IDX_W{1'b0}};
    anyLocked = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      // Disabled entries count as well: any lock bit freezes a clear bypass
      anyLocked = anyLocked | cfgMem[i][`MMLPC_CFG_L_BIT]; // RL5
      case (matchMode(cfgMem[i]))
        `MMLPC_A_TOR: begin
          if (i == 0) begin
            if (chkWord < addrMem[i]) begin // RL22
              hit    = 1'b1;
              hitIdx = i[IDX_W-1:0]; // RL23
            end
          end else if (addrMem[i-1] < addrMem[i] && // RL22
                       chkWord >= addrMem[i-1] && chkWord < addrMem[i]) begin
            hit    = 1'b1;
            hitIdx = i[IDX_W-1:0]; // RL23
          end
        end
        `MMLPC_A_NA4: begin
          if (chkWord == addrMem[i]) begin
            hit    = 1'b1;
            hitIdx = i[IDX_W-1:0]; // RL23
          end
        end
        `MMLPC_A_NAPOT: begin
          if (napotHit(addrMem[i], chkWord)) begin
            hit    = 1'b1;
            hitIdx = i[IDX_W-1:0]; // RL23
          end
        end
        default: begin
        end
      endcase
    end
    hitLrwx = lrwxOf(cfgMem[hitIdx]);
  end

  mmlpc_entry_perm u_perm (
    .matched                (hit),
    .lrwx                   (hitLrwx),
    .machineLockdown        (machineLockdown),
    .machineAllowlistPolicy (machineAllowlistPolicy),
    .isMachine              (chkIsM),
    .accType                (chkType),
    .allow                  (allow)
  );

  // Access check answers one cycle after the request
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      chkDone    <= 1'b0;
      chkFault   <= 1'b0;
      chkMatched <= 1'b0;
      chkEntry   <= {IDX_W{1'b0}};
    end else begin
      chkDone <= chkValid;
      if (chkValid) begin
        chkFault   <= ~allow; // RL21
        chkMatched <= hit;
        chkEntry   <= hitIdx;
      end
    end
  end

  // Configuration register decode
  always @* begin
    csrIsM      = (csrPriv == `MMLPC_PRIV_M); // RL1
    csrMapped   = (csrAddr == `MMLPC_SECCFG_ADDR) || (XLEN == 32 && csrAddr == `MMLPC_SECCFG_HI_ADDR); // RL1
    secCfgWide  = {61'h0, secCfg}; // RL2
    next_rdData = {XLEN{1'b0}};
    if (csrAddr == `MMLPC_SECCFG_ADDR) begin
      next_rdData = secCfgWide[XLEN-1:0];
    end else if (XLEN == 32) begin
      next_rdData = secCfgWide[63:64-XLEN];
    end
    next_secCfg = secCfg;
    if (secCfgWr) begin
      next_secCfg[`MMLPC_SECCFG_MML_BIT]  = secCfg[`MMLPC_SECCFG_MML_BIT]
                                            | csrWrData[`MMLPC_SECCFG_MML_BIT]; // RL9
      next_secCfg[`MMLPC_SECCFG_MACHINE_ALLOWLIST_POLICY_BIT] = secCfg[`MMLPC_SECCFG_MACHINE_ALLOWLIST_POLICY_BIT]
                                            | csrWrData[`MMLPC_SECCFG_MACHINE_ALLOWLIST_POLICY_BIT]; // RL7
      if (RLB_EN == 0) begin
        next_secCfg[`MMLPC_SECCFG_RLB_BIT] = 1'b0; // RL6
      end else if (!secCfg[`MMLPC_SECCFG_RLB_BIT] && anyLocked) begin
        next_secCfg[`MMLPC_SECCFG_RLB_BIT] = 1'b0; // RL5
      end else begin
        next_secCfg[`MMLPC_SECCFG_RLB_BIT] = csrWrData[`MMLPC_SECCFG_RLB_BIT]; // RL2
      end
    end
  end

  // Read data shows the value from before a write in the same cycle
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      secCfg     <= SECCFG_RST[2:0]; // RL3
      csrAck     <= 1'b0;
      csrIllegal <= 1'b0;
      csrRdData  <= {XLEN{1'b0}};
    end else begin
      secCfg     <= next_secCfg;
      csrAck     <= csrValid;
      csrIllegal <= csrValid & ~(csrIsM & csrMapped); // RL1
      if (csrValid && csrIsM && csrMapped) begin
        csrRdData <= next_rdData;
      end else begin
        csrRdData <= {XLEN{1'b0}};
      end
    end
  end

  // Entry configuration and address registers; a locked TOR entry also guards the address below it
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      for (j = 0; j < N; j = j + 1) begin
        cfgMem[j]  <= `MMLPC_CFG_RESET;
        addrMem[j] <= {AW{`MMLPC_ADDR_RESET}};
      end
    end else begin
      if (cfgWrEn && !entryLocked(cfgMem[cfgWrIdx], ruleLockBypass)) begin // RL17
        if (!(machineLockdown && !ruleLockBypass && execLockedCfg(cfgWrData))) begin // RL18
          cfgMem[cfgWrIdx] <= cfgWrData;
        end
      end
      if (addrWrEn && !entryLocked(cfgMem[addrWrIdx], ruleLockBypass)) begin // RL17
        if (addrWrIdx == N - 1) begin
          addrMem[addrWrIdx] <= addrWrData;
        end else if (!torGuarded(cfgMem[addrWrIdx + 1'b1], ruleLockBypass)) begin
          addrMem[addrWrIdx] <= addrWrData; // RL4
        end
      end
    end
  end

  // Entry read-back trails the index by one cycle
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      entryRdCfg  <= `MMLPC_CFG_RESET;
      entryRdAddr <= {AW{`MMLPC_ADDR_RESET}};
    end else begin
      entryRdCfg  <= cfgMem[entryRdIdx];
      entryRdAddr <= addrMem[entryRdIdx];
    end
  end

endmodule

// file: test/mmlpc_sva_checker.sv
// Port assertions for the lockdown protection checker
`timescale 1ns/10ps
module mmlpc_sva_checker #(
  parameter XLEN = 32
) (
  input wire            sys_clk,
  input wire            reset_n,
  input wire            csrValid,
  input wire            csrWrite,
  input wire [11:0]     csrAddr,
  input wire [XLEN-1:0] csrWrData,
  input wire [1:0]      csrPriv,
  input wire            csrAck,
  input wire            csrIllegal,
  input wire [XLEN-1:0] csrRdData,
  input wire            chkValid,
  input wire [1:0]      chkType,
  input wire [1:0]      chkPriv,
  input wire            chkDone,
  input wire            chkFault,
  input wire            chkMatched,
  input wire            ruleLockBypass,
  input wire            machineAllowlistPolicy,
  input wire            machineLockdown
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence mWrite;
    csrValid && csrWrite && csrPriv == 2'h3 && csrAddr == 12'h747;
  endsequence
  sequence mAccess;
    chkValid && chkPriv == 2'h3;
  endsequence
  AST_CSR_ACK: assert property (csrValid |=> csrAck && !(|csrRdData[XLEN-1:3]))
    else $error("csr answer wrong");
  AST_CSR_PRIV: assert property (csrValid && csrPriv != 2'h3 |=> csrIllegal && !(|csrRdData))
    else $error("non machine access not refused");
  AST_MML_SET: assert property (mWrite ##0 csrWrData[0] |=> machineLockdown)
    else $error("lockdown not set");
  AST_MML_STICKY: assert property (machineLockdown |=> machineLockdown)
    else $error("lockdown cleared");
  AST_MACHINE_ALLOWLIST_POLICY_STICKY: assert property (machineAllowlistPolicy |=> $stable(machineAllowlistPolicy))
    else $error("allowlist cleared");
  AST_RLB_HOLD: assert property (!ruleLockBypass && !(csrValid && csrWrite && csrWrData[2]) |=> !ruleLockBypass)
    else $error("bypass rose unasked");
  // Checked through reset, so no disable here
  AST_RESET: assert property (disable iff (1'b0) !reset_n |=> !machineLockdown && !machineAllowlistPolicy && !ruleLockBypass)
    else $error("config not cleared");
  AST_MACHINE_ALLOWLIST_POLICY_DENY: assert property (mAccess ##0 machineAllowlistPolicy |=> chkDone && (chkMatched || chkFault))
    else $error("unmatched machine access allowed");
  AST_MML_FETCH: assert property (mAccess ##0 chkType == 2'h2 && machineLockdown |=> chkMatched || chkFault)
    else $error("unmatched machine fetch allowed");
endmodule

bind mmlpc_checker mmlpc_sva_checker #(.XLEN(XLEN)) mmlpc_sva_checker_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .csrValid(csrValid), .csrWrite(csrWrite), .csrAddr(csrAddr),
  .csrWrData(csrWrData), .csrPriv(csrPriv), .csrAck(csrAck), .csrIllegal(csrIllegal), .csrRdData(csrRdData),
  .chkValid(chkValid), .chkType(chkType), .chkPriv(chkPriv), .chkDone(chkDone), .chkFault(chkFault),
  .chkMatched(chkMatched), .ruleLockBypass(ruleLockBypass),
  .machineAllowlistPolicy(machineAllowlistPolicy), .machineLockdown(machineLockdown));

// file: test/mmlpc_hart_model.sv
// Hart access path model presenting one protection check per request
`timescale 1ns/10ps
module mmlpc_hart_model (
  input  wire        sys_clk,
  input  wire        go,
  input  wire [11:0] gAddr,
  input  wire [1:0]  gType,
  input  wire [1:0]  gPriv,
  input  wire        chkDone,
  input  wire        chkFault,
  output reg         chkValid,
  output reg  [33:0] chkAddr,
  output reg  [1:0]  chkType,
  output reg  [1:0]  chkPriv,
  output reg         done,
  output reg         fault
);
  initial begin
    {chkValid, chkAddr, chkType, chkPriv, done, fault} = 41'h0;
  end
  // Idle lines toggle so a stale request never looks valid
  always @(posedge sys_clk) begin
    chkValid <= go;
    chkAddr <= go ? {22'h0, gAddr} : ~chkAddr;
    chkType <= go ? gType : ~chkType;
    chkPriv <= go ? gPriv : ~chkPriv;
    done <= chkDone;
    if (chkDone) begin
      fault <= chkFault;
    end
  end
endmodule

// file: test/tb.sv
// Self-checking bench for the lockdown protection checker
`timescale 1ns/10ps
module tb;
  reg         sys_clk = 1'b0, reset_n = 1'b0, csrValid = 1'b0, csrWrite = 1'b0, cfgWrEn = 1'b0, go = 1'b0;
  reg  [11:0] csrAddr = 12'h0, gAddr = 12'h0;
  reg  [31:0] csrWrData = 32'h0, addrWrData = 32'h0;
  reg  [1:0]  csrPriv = 2'h3, gType = 2'h0, gPriv = 2'h0;
  reg  [2:0]  cfgWrIdx = 3'h0, rdIdx = 3'h0;
  reg  [7:0]  cfgWrData = 8'h0;
  wire        csrAck, csrIllegal, chkValid, chkDone, chkFault, done, fault;
  wire [31:0] csrRdData;
  wire [33:0] chkAddr;
  wire [1:0]  chkType, chkPriv;
  wire [7:0]  rdCfg;
  wire [31:0] rdAddr;
  wire [2:0]  hitEntry;
  wire        hitMatched, ruleLockBypass, machineAllowlistPolicy, machineLockdown;
  integer     fail_count = 0, checks = 0, i, n;
  localparam [63:0] CFGS = 64'h07179E1017121091;
  localparam [95:0] ADRS = 96'h300100700600500400200100;
  // Row: address, access type, privilege, expected fault
  reg  [23:0] rows [0:25] = '{24'h100030, 24'h100131, 24'h200130, 24'h200001, 24'h300030, 24'h300001,
    24'h400101, 24'h700131, 24'h300031, 24'h100030, 24'h100001, 24'h500100, 24'h500031, 24'h400130,
    24'h400000, 24'h400101, 24'h400231, 24'h700230, 24'h700030, 24'h700131, 24'h700200, 24'h600030,
    24'h600131, 24'h600201, 24'h300231, 24'h100231};

  always #4 sys_clk = ~sys_clk;

  mmlpc_checker mmlpc_checker_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .csrValid(csrValid), .csrWrite(csrWrite), .csrAddr(csrAddr),
    .csrWrData(csrWrData), .csrPriv(csrPriv), .csrAck(csrAck), .csrIllegal(csrIllegal), .csrRdData(csrRdData),
    .cfgWrEn(cfgWrEn), .cfgWrIdx(cfgWrIdx), .cfgWrData(cfgWrData), .addrWrEn(cfgWrEn), .addrWrIdx(cfgWrIdx),
    .addrWrData(addrWrData), .entryRdIdx(rdIdx), .entryRdCfg(rdCfg), .entryRdAddr(rdAddr), .chkValid(chkValid),
    .chkAddr(chkAddr), .chkType(chkType), .chkPriv(chkPriv), .chkDone(chkDone), .chkFault(chkFault),
    .chkMatched(hitMatched), .chkEntry(hitEntry), .ruleLockBypass(ruleLockBypass),
    .machineAllowlistPolicy(machineAllowlistPolicy), .machineLockdown(machineLockdown));

  mmlpc_hart_model mmlpc_hart_model_inst (
    .sys_clk(sys_clk), .go(go), .gAddr(gAddr), .gType(gType), .gPriv(gPriv), .chkDone(chkDone),
    .chkFault(chkFault), .chkValid(chkValid), .chkAddr(chkAddr), .chkType(chkType), .chkPriv(chkPriv),
    .done(done), .fault(fault));

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task cmp(input [33:0] got, input [33:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Address packs privilege above the register number; expectation packs illegal above data
  task csr(input w, input [13:0] pa, input [31:0] d, input [32:0] e);
    begin
      @(negedge sys_clk);
      {csrValid, csrWrite, csrPriv, csrAddr, csrWrData} = {1'b1, w, pa, d};
      @(negedge sys_clk);
      csrValid = 1'b0;
      cmp({csrAck, csrIllegal, csrRdData}, {1'b1, e});
    end
  endtask

  task ent(input [2:0] x, input [7:0] c, input [11:0] a);
    begin
      @(negedge sys_clk);
      {cfgWrEn, cfgWrIdx, cfgWrData, addrWrData} = {1'b1, x, c, 22'h0, a[11:2]};
      @(negedge sys_clk);
      cfgWrEn = 1'b0;
    end
  endtask

  task rd(input [2:0] x, input [7:0] e);
    begin
      rdIdx = x;
      @(negedge sys_clk);
      cmp({26'h0, rdCfg}, {26'h0, e});
    end
  endtask

  task chk(input [23:0] r);
    begin
      @(negedge sys_clk);
      {gAddr, gType, gPriv, go} = {r[23:12], r[9:8], r[5:4], 1'b1};
      @(negedge sys_clk);
      go = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (done !== 1'b1) begin
        fail_count = fail_count + 1;
        finish_test;
      end else begin
        cmp({33'h0, fault}, {33'h0, r[0]});
      end
    end
  endtask

  initial begin
    #100000;
    fail_count = fail_count + 1;
    finish_test;
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    csr(1'b0, 14'h3747, 32'h0, 33'h0);
    csr(1'b0, 14'h3757, 32'h0, 33'h0);
    csr(1'b0, 14'h1747, 32'h0, 33'h100000000);
    csr(1'b0, 14'h3123, 32'h0, 33'h100000000);
    csr(1'b1, 14'h3747, 32'hFFFFFFFC, 33'h0);
    csr(1'b0, 14'h3747, 32'h0, 33'h4);
    for (i = 0; i < 8; i = i + 1)
      ent(i[2:0], CFGS[i*8+:8], ADRS[i*12+:12]);
    ent(3'h0, 8'h90, 12'h100);
    rd(3'h0, 8'h90);
    ent(3'h0, 8'h91, 12'h100);
    csr(1'b1, 14'h3747, 32'h0, 33'h4);
    csr(1'b1, 14'h3747, 32'h4, 33'h0);
    csr(1'b0, 14'h3747, 32'h0, 33'h0);
    for (i = 0; i < 8; i = i + 1)
      chk(rows[i]);
    csr(1'b1, 14'h3747, 32'h2, 33'h0);
    csr(1'b1, 14'h3747, 32'h0, 33'h2);
    csr(1'b1, 14'h3747, 32'h1, 33'h2);
    csr(1'b0, 14'h3747, 32'h0, 33'h3);
    cmp({31'h0, ruleLockBypass, machineAllowlistPolicy, machineLockdown}, 34'h3);
    ent(3'h4, 8'h9F, 12'h600);
    rd(3'h4, 8'h9F);
    ent(3'h1, 8'h94, 12'h200);
    rd(3'h1, 8'h10);
    ent(3'h0, 8'h10, 12'h100);
    rd(3'h0, 8'h91);
    for (i = 8; i < 26; i = i + 1)
      chk(rows[i]);
    cmp({30'h0, hitMatched, hitEntry}, {30'h0, 1'b1, 3'h0});
    @(negedge sys_clk);
    reset_n = 1'b0;
    @(negedge sys_clk);
    reset_n = 1'b1;
    csr(1'b0, 14'h3747, 32'h0, 33'h0);
    rd(3'h0, 8'h00);
    ent(3'h0, 8'h09, 12'h200);
    rd(3'h0, 8'h09);
    cmp({2'h0, rdAddr}, 34'h80);
    chk(24'h100000);
    chk(24'h300001);
    finish_test;
  end
endmodule
